// ---- shared/dfr_consts.svh ----
// offsets, field positions, reset values and sizes for the data flash row access block
`ifndef DFR_CONSTS_SVH
`define DFR_CONSTS_SVH
// ------------------------------------------------------------
// command codes
// ------------------------------------------------------------
`define DFR_CMD_SETUP     8'h00
`define DFR_CMD_BLOCK     8'h2F
`define DFR_CMD_PARAM     8'h30
`define DFR_CMD_USER      8'h31
`define DFR_CMD_STATUS    8'h50
`define DFR_CMD_MINV      8'h51
`define DFR_CMD_PROG      8'h52
// ------------------------------------------------------------
// fields and sizes
// ------------------------------------------------------------
`define DFR_SETUP_TAG     8'h01
`define DFR_ROW_BYTES     32
`define DFR_ROW_LAST      5'h1F
`define DFR_ROW_BITS      4
`define DFR_ADDR_BITS     9
`define DFR_USER_BASE     9'h1A0
`define DFR_USER_LAST     7'h5F
`define DFR_PARAM_ADDR    9'h000
`define DFR_FLG_SEC       0
`define DFR_FLG_VOLT      1
`define DFR_FLG_BUSY      2
`define DFR_FLG_DONE      3
`define DFR_MINV_RST      16'h0BB8
`endif

// ---- shared/dfr_pkg.sv ----
// types shared by the data flash row access block
package dfr_pkg;
  typedef enum logic [1:0] {
    DFR_MODE_FULL,
    DFR_MODE_OPEN,
    DFR_MODE_LOCKED
  } dfr_mode_e;
  typedef enum logic {
    DFR_ST_IDLE,
    DFR_ST_PROG
  } dfr_state_e;
  typedef struct packed {
    dfr_state_e   st;
    logic [7:0]   row;
    logic [4:0]   idx;
    logic [6:0]   uidx;
    logic [4:0]   pcnt;
    logic [255:0] stage;
    logic [15:0]  minv;
    logic [3:0]   flags;
    logic         rsel;
    logic [15:0]  rdata;
    logic         prog;
  } dfr_state_s;
endpackage : dfr_pkg

// ---- verification/dfr_host.sv ----
// host model: row setup, block moves, byte updates
`timescale 1ns/100ps
`include "dfr_consts.svh"
module dfr_host (
  input  wire logic        clock, // clk
  output logic      [7:0]  addr,  // cmd
  output logic      [15:0] wdata, // data
  output logic             wr,    // write
  output logic             rd,    // read
  input  wire logic [15:0] rdata  // answer
);
  // bus idles with strobes low
  initial begin
    addr = 8'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end
  // data inverted after the taking edge so a stale value never looks valid
  task automatic wcmd(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    wdata <= ~d;
  endtask : wcmd
  task automatic rcmd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rcmd
  // whole row moves, each after a fresh setup
  task automatic wrow(input logic [7:0] r, input logic [7:0] b [32]);
    wcmd(`DFR_CMD_SETUP, {`DFR_SETUP_TAG, r});
    for (int i = 0; i < 32; i++) begin
      wcmd(`DFR_CMD_BLOCK, {8'h00, b[i]});
    end
    repeat (36) @(posedge clock);
  endtask : wrow
  task automatic rrow(input logic [7:0] r, output logic [7:0] b [32]);
    logic [15:0] d;
    wcmd(`DFR_CMD_SETUP, {`DFR_SETUP_TAG, r});
    for (int i = 0; i < 32; i++) begin
      rcmd(`DFR_CMD_BLOCK, d);
      b[i] = d[7:0];
    end
  endtask : rrow
  // read-modify-write of one byte, then read-back
  task automatic upd(input int loc, input logic [7:0] val, output logic [7:0] v [32]);
    logic [7:0] r;
    logic [7:0] b [32];
    r = 8'(loc / 32);
    rrow(r, b);
    b[loc - r * 32] = val;
    wrow(r, b);
    rrow(r, v);
  endtask : upd
endmodule : dfr_host

// ---- verification/dfr_row_access_props.sv ----
// checker bound to the row access ports
`timescale 1ns/100ps
`include "dfr_consts.svh"
module dfr_row_access_props
  import dfr_pkg::*;
(
  input wire logic        clock,      // clk
  input wire logic        rst,        // reset
  input wire logic [7:0]  addr,       // cmd
  input wire logic [15:0] wdata,      // data
  input wire logic        wr,         // write
  input wire logic        rd,         // read
  input wire logic [15:0] rdata,      // answer
  input wire dfr_mode_e   sec_mode,   // mode
  input wire logic [15:0] voltage_mv, // volts
  input wire logic        flash_busy, // busy
  input wire logic        prog_start  // pulse
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic [5:0] blen_r; // busy cycles so far
  // counter, since 32 cycles is too long for a repetition
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      blen_r <= 6'h0;
    end else begin
      blen_r <= flash_busy ? blen_r + 6'h1 : 6'h0;
    end
  end
  property p_tag; rd && addr == `DFR_CMD_SETUP |=> rdata[15:8] == `DFR_SETUP_TAG; endproperty
  a_tag: assert property (p_tag) else $error("setup tag");
  property p_bcause; $rose(flash_busy) |-> $past(wr && addr == `DFR_CMD_BLOCK); endproperty
  a_bcause: assert property (p_bcause) else $error("busy cause");
  property p_blen; $fell(flash_busy) |-> blen_r == 6'h20; endproperty
  a_blen: assert property (p_blen) else $error("busy length");
  property p_lkrd; rd && addr == `DFR_CMD_BLOCK && sec_mode == DFR_MODE_LOCKED
    |=> rdata == 16'h0000; endproperty
  a_lkrd: assert property (p_lkrd) else $error("locked block read");
  property p_lkext; rd && addr == `DFR_CMD_STATUS && sec_mode == DFR_MODE_LOCKED
    |=> rdata == 16'h0000; endproperty
  a_lkext: assert property (p_lkext) else $error("locked extended read");
  property p_lkwr; wr && addr == `DFR_CMD_BLOCK && sec_mode == DFR_MODE_LOCKED
    && !flash_busy |=> !flash_busy; endproperty
  a_lkwr: assert property (p_lkwr) else $error("locked write programs");
  property p_pcause; prog_start |-> $past(wr && addr == `DFR_CMD_PROG
    && sec_mode == DFR_MODE_FULL); endproperty
  a_pcause: assert property (p_pcause) else $error("stray prog pulse");
  property p_ptake; wr && addr == `DFR_CMD_PROG && sec_mode == DFR_MODE_FULL
    && !flash_busy |=> prog_start; endproperty
  a_ptake: assert property (p_ptake) else $error("prog pulse missing");
  c_busy: cover property ($rose(flash_busy));
  c_prog: cover property (prog_start);
  c_lock: cover property (rd && sec_mode == DFR_MODE_LOCKED);
endmodule : dfr_row_access_props
bind dfr_row_access dfr_row_access_props u_dfr_row_access_props (.clock(clock), .rst(rst),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sec_mode(sec_mode),
  .voltage_mv(voltage_mv), .flash_busy(flash_busy), .prog_start(prog_start));

// ---- verification/dfr_row_access_tb.sv ----
// self-checking bench for the row access block
`timescale 1ns/100ps
`include "dfr_consts.svh"
module dfr_row_access_tb
  import dfr_pkg::*;
;
  logic        clock, rst, wr, rd, flash_busy, prog_start;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, voltage_mv, v;
  dfr_mode_e   sec_mode;
  logic [7:0]  pat [32];
  logic [7:0]  got [32];
  int          err_count, compares, cyc;
  dfr_row_access u_dfr_row_access (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .sec_mode(sec_mode), .voltage_mv(voltage_mv),
    .flash_busy(flash_busy), .prog_start(prog_start));
  dfr_host u_dfr_host (.clock(clock), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata));
  always #2.5 clock = ~clock;
  // hang guard, well above the under one thousand cycles the run needs
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic chk_row();
    for (int i = 0; i < 32; i++) begin
      chk("row byte", 16'(got[i]), 16'(pat[i]));
    end
  endtask : chk_row
  task automatic give_verdict();
    if (err_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict
  // update at exactly the threshold voltage
  task automatic t_update();
    @(posedge clock);
    voltage_mv <= `DFR_MINV_RST;
    u_dfr_host.wrow(8'h00, pat);
    u_dfr_host.rcmd(`DFR_CMD_SETUP, v);
    chk("setup echo", v, 16'h0100);
    u_dfr_host.upd(27, 8'hC3, got);
    pat[27] = 8'hC3;
    chk_row();
  endtask : t_update
  // commit of the first row of user bytes, poked while it programs
  task automatic t_busy();
    @(posedge clock);
    sec_mode <= DFR_MODE_FULL;
    voltage_mv <= `DFR_MINV_RST;
    u_dfr_host.wcmd(`DFR_CMD_STATUS, 16'h000F);
    u_dfr_host.wcmd(`DFR_CMD_SETUP, {`DFR_SETUP_TAG, 8'h0D});
    for (int i = 0; i < 32; i++) begin
      u_dfr_host.wcmd(`DFR_CMD_BLOCK, {8'h00, pat[i]});
    end
    #1 chk("busy on commit", 16'(flash_busy), 16'h0001);
    u_dfr_host.rcmd(`DFR_CMD_STATUS, v);
    chk("busy bit", v & 16'h0010, 16'h0010);
    u_dfr_host.rcmd(`DFR_CMD_SETUP, v);
    chk("setup echo busy", v, 16'h010D);
    u_dfr_host.wcmd(`DFR_CMD_BLOCK, 16'h00AA);
    u_dfr_host.rcmd(`DFR_CMD_STATUS, v);
    chk("busy refuse", 16'(v[`DFR_FLG_BUSY]), 16'h0001);
    repeat (36) @(posedge clock);
    #1 chk("busy off", 16'(flash_busy), 16'h0000);
    u_dfr_host.rcmd(`DFR_CMD_STATUS, v);
    chk("done flag", 16'(v[`DFR_FLG_DONE]), 16'h0001);
    u_dfr_host.wcmd(`DFR_CMD_USER, 16'h0100);
    u_dfr_host.rcmd(`DFR_CMD_USER, v);
    chk("user byte 0", v, 16'(pat[0]));
    u_dfr_host.rcmd(`DFR_CMD_USER, v);
    chk("user byte 1", v, 16'(pat[1]));
    u_dfr_host.wcmd(`DFR_CMD_MINV, 16'h1000);
    u_dfr_host.rcmd(`DFR_CMD_MINV, v);
    chk("min volt", v, 16'h1000);
    u_dfr_host.wcmd(`DFR_CMD_MINV, `DFR_MINV_RST);
  endtask : t_busy
  // one millivolt low: row must survive
  task automatic t_low_volt();
    @(posedge clock);
    voltage_mv <= `DFR_MINV_RST - 16'h0001;
    foreach (got[i]) got[i] = ~pat[i];
    u_dfr_host.wrow(8'h00, got);
    u_dfr_host.rcmd(`DFR_CMD_STATUS, v);
    chk("volt flag", 16'(v[`DFR_FLG_VOLT]), 16'h0001);
    u_dfr_host.rrow(8'h00, got);
    chk_row();
  endtask : t_low_volt
  task automatic t_locked();
    @(posedge clock);
    sec_mode <= DFR_MODE_LOCKED;
    voltage_mv <= `DFR_MINV_RST;
    foreach (got[i]) got[i] = ~pat[i];
    u_dfr_host.wrow(8'h00, got);
    u_dfr_host.rrow(8'h00, got);
    chk("locked read", 16'(got[0]), 16'h0000);
    u_dfr_host.rcmd(`DFR_CMD_STATUS, v);
    chk("locked status", v, 16'h0000);
    u_dfr_host.rcmd(`DFR_CMD_PARAM, v);
    chk("param byte", 16'(v[7:0]), 16'(pat[0]));
    @(posedge clock);
    sec_mode <= DFR_MODE_OPEN;
    u_dfr_host.rrow(8'h00, got);
    chk_row();
  endtask : t_locked
  task automatic t_prog();
    @(posedge clock);
    sec_mode <= DFR_MODE_FULL;
    u_dfr_host.wcmd(`DFR_CMD_PROG, 16'h0000);
    #1 chk("prog full", 16'(prog_start), 16'h0001);
    @(posedge clock);
    sec_mode <= DFR_MODE_OPEN;
    u_dfr_host.wcmd(`DFR_CMD_STATUS, 16'h000F);
    u_dfr_host.wcmd(`DFR_CMD_PROG, 16'h0000);
    #1 chk("prog open", 16'(prog_start), 16'h0000);
    u_dfr_host.rcmd(`DFR_CMD_STATUS, v);
    chk("sec flag", 16'(v[`DFR_FLG_SEC]), 16'h0001);
  endtask : t_prog
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    sec_mode = DFR_MODE_FULL;
    voltage_mv = 16'h0000;
    err_count = 0;
    compares = 0;
    cyc = 0;
    foreach (pat[i]) pat[i] = 8'(i) * 8'h07 + 8'h11;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    t_update();
    t_busy();
    t_low_volt();
    t_locked();
    t_prog();
    give_verdict();
  end
endmodule : dfr_row_access_tb

// ---- verilog/dfr_row_access.sv ----
// data flash row access: row setup, 32-byte block moves, security and voltage gating
// ------------------------------------------------------------
// ------------------------------------------------------------
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`include "dfr_consts.svh"
module dfr_row_access
  import dfr_pkg::*;
(
  input  wire logic        clock,      // 200 MHz system clock
  input  wire logic        rst,        // async reset, high
  input  wire logic [7:0]  addr,       // command code
  input  wire logic [15:0] wdata,      // write data
  input  wire logic        wr,         // write strobe
  input  wire logic        rd,         // read strobe
  output logic      [15:0] rdata,      // read data, cycle after rd
  input  wire dfr_mode_e   sec_mode,   // current security mode
  input  wire logic [15:0] voltage_mv, // measured battery voltage
  output logic             flash_busy, // row programming in progress
  output logic             prog_start  // device programming request pulse
);
  dfr_state_s s_r;
  dfr_state_s s_nxt;
  logic [`DFR_ADDR_BITS-1:0] mem_addr;
  logic                      mem_we;
  logic [7:0]                mem_wdata;
  logic [7:0]                mem_q;
  logic                      open_ok;
  logic                      full_ok;
  logic                      busy;
  logic [3:0]                fset;
  logic [3:0]                fclr;

  // ------------------------------------------------------------
  // flash array
  // ------------------------------------------------------------
  dfr_row_mem u_mem (
    .clock (clock),
    .rst   (rst),
    .addr  (mem_addr),
    .wen   (mem_we),
    .wdata (mem_wdata),
    .q     (mem_q)
  );

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  // full and open both reach general flash; locked only standard commands
  assign full_ok = (sec_mode == DFR_MODE_FULL);
  assign open_ok = full_ok || (sec_mode == DFR_MODE_OPEN);
  assign busy    = (s_r.st == DFR_ST_PROG);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_nxt     = s_r;
    s_nxt.prog = 1'b0;
    mem_we    = 1'b0;
    mem_wdata = s_r.stage[{s_r.pcnt, 3'b000} +: 8];
    mem_addr  = {s_r.row[`DFR_ROW_BITS-1:0], s_r.idx};
    fset      = 4'h0;
    fclr      = 4'h0;
    // read-side address choice follows the command being read
    unique case (addr)
      `DFR_CMD_USER:  mem_addr = `DFR_USER_BASE + {2'b00, s_r.uidx};
      `DFR_CMD_PARAM: mem_addr = `DFR_PARAM_ADDR;
      default:        mem_addr = {s_r.row[`DFR_ROW_BITS-1:0], s_r.idx};
    endcase
    if (rd) begin
      s_nxt.rsel  = 1'b0;
      s_nxt.rdata = 16'h0000;
    end
    unique case (s_r.st)
      DFR_ST_IDLE: begin
        if (wr) begin
          unique case (addr)
            `DFR_CMD_SETUP: begin
              if (wdata[15:8] == `DFR_SETUP_TAG) begin
                s_nxt.row = wdata[7:0];
                s_nxt.idx = 5'h00;
              end
            end
            `DFR_CMD_BLOCK: begin
              if (!open_ok) begin
                fset[`DFR_FLG_SEC] = 1'b1;
              end else begin
                s_nxt.stage[{s_r.idx, 3'b000} +: 8] = wdata[7:0];
                s_nxt.idx = s_r.idx + 5'h01;
                if (s_r.idx == `DFR_ROW_LAST) begin
                  // only the 32nd byte commits, so a short burst never programs
                  if (voltage_mv >= s_r.minv) begin
                    s_nxt.st   = DFR_ST_PROG;
                    s_nxt.pcnt = 5'h00;
                  end else begin
                    fset[`DFR_FLG_VOLT] = 1'b1;
                  end
                end
              end
            end
            `DFR_CMD_USER: begin
              if (wdata[15:8] == `DFR_SETUP_TAG) begin
                s_nxt.uidx = 7'h00;
              end
            end
            `DFR_CMD_STATUS: begin
              if (open_ok) begin
                fclr = wdata[3:0];
              end
            end
            `DFR_CMD_MINV: begin
              if (full_ok) begin
                s_nxt.minv = wdata;
              end
            end
            `DFR_CMD_PROG: begin
              if (full_ok) begin
                s_nxt.prog = 1'b1;
              end else begin
                fset[`DFR_FLG_SEC] = 1'b1;
              end
            end
            default: begin
            end
          endcase
        end
      end
      DFR_ST_PROG: begin
        // one byte a cycle; array port belongs to programming meanwhile
        mem_addr = {s_r.row[`DFR_ROW_BITS-1:0], s_r.pcnt};
        mem_we   = 1'b1;
        s_nxt.pcnt = s_r.pcnt + 5'h01;
        if (s_r.pcnt == `DFR_ROW_LAST) begin
          s_nxt.st = DFR_ST_IDLE;
          fset[`DFR_FLG_DONE] = 1'b1;
        end
        if (wr || (rd && (addr == `DFR_CMD_BLOCK || addr == `DFR_CMD_USER
                          || addr == `DFR_CMD_PARAM))) begin
          fset[`DFR_FLG_BUSY] = 1'b1;
        end
      end
    endcase
    // reads: flash bytes come from the array register, the rest from here
    // while programming only the flash-backed reads are turned away, status stays readable
    if (rd && !(busy && (addr == `DFR_CMD_BLOCK || addr == `DFR_CMD_USER
                         || addr == `DFR_CMD_PARAM))) begin
      unique case (addr)
        `DFR_CMD_SETUP: s_nxt.rdata = {`DFR_SETUP_TAG, s_r.row};
        `DFR_CMD_BLOCK: begin
          if (open_ok) begin
            s_nxt.rsel = 1'b1;
            s_nxt.idx  = s_r.idx + 5'h01;
          end else begin
            fset[`DFR_FLG_SEC] = 1'b1;
          end
        end
        `DFR_CMD_PARAM: s_nxt.rsel = 1'b1;
        `DFR_CMD_USER: begin
          s_nxt.rsel = 1'b1;
          s_nxt.uidx = (s_r.uidx == `DFR_USER_LAST) ? 7'h00 : s_r.uidx + 7'h01;
        end
        `DFR_CMD_STATUS: begin
          if (open_ok) begin
            s_nxt.rdata = {11'h000, busy, s_r.flags};
          end
        end
        `DFR_CMD_MINV: begin
          if (open_ok) begin
            s_nxt.rdata = s_r.minv;
          end
        end
        default: begin
        end
      endcase
    end
    // hardware set wins over a software clear in the same cycle
    s_nxt.flags = (s_r.flags & ~fclr) | fset;
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_r       <= '0;
      s_r.st    <= DFR_ST_IDLE;
      s_r.minv  <= `DFR_MINV_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign rdata      = s_r.rsel ? {8'h00, mem_q} : s_r.rdata;
  assign flash_busy = busy;
  assign prog_start = s_r.prog;
endmodule : dfr_row_access

// ---- verilog/dfr_row_mem.sv ----
// byte-wide flash array with one synchronous port
`timescale 1ns/100ps
`include "dfr_consts.svh"
module dfr_row_mem (
  input  wire logic                      clock, // system clock
  input  wire logic                      rst,   // async reset, high
  input  wire logic [`DFR_ADDR_BITS-1:0] addr,  // byte address
  input  wire logic                      wen,   // program one byte
  input  wire logic [7:0]                wdata, // byte to program
  output logic      [7:0]                q      // byte read, one cycle later
);
  logic [7:0] mem [0:(1<<`DFR_ADDR_BITS)-1];

  // ------------------------------------------------------------
  // array port
  // ------------------------------------------------------------
  // array itself has no reset, like real flash it keeps what it holds
  always_ff @(posedge clock) begin
    if (wen) begin
      mem[addr] <= wdata;
    end
  end

  // read register, reset so the output is defined from the start
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= 8'h00;
    end else begin
      q <= mem[addr];
    end
  end
endmodule : dfr_row_mem
